// >>> hw/sdpr_port_ram.sv
// Notes on behaviour
// - Port selected only with active-low select LOW and active-high select HIGH.
// - Either select inactive deselects the port; data pins float after that edge in flow-through mode, one edge later in pipelined mode.
// - Selected edge: read_not_write LOW writes; HIGH with drive enabled reads out.
// - Output disable acts without the clock; HIGH floats the data pins.
// - All other inputs are sampled only at the rising clock edge.
// - Pipelined mode: select changes show one cycle after the sampling edge.
// - Count clear LOW forces counter to zero and accesses word zero.
// - Strobe LOW with clear HIGH loads and accesses the external address.
// - Strobe, advance and clear all HIGH hold counter and reaccess that word.
// - Advance LOW with strobe and clear HIGH increments and accesses next word.
// - Array address is zero when clear LOW, else pin address when strobe LOW, counter when HIGH.
// - Counter actions ignore both chip selects.
// - Counter clear inserts no idle cycle; access at zero happens same edge.
// - Pipelined read data lags flow-through by exactly one cycle.
// - Pin drive state follows controls sampled one cycle earlier in flow-through mode, two cycles earlier in pipelined mode.
// - Cross-port write then read sees new data once clock spacing allows.
// - Mode select LOW gives flow-through output, HIGH gives pipelined output.
// - Same-word writes from both ports give no guaranteed result.
module sdpr_port_ram #(
   parameter int ADDR_W = sdpr_pkg::DEF_ADDR_W,
   parameter int DATA_W = sdpr_pkg::DEF_DATA_W
) (
   input  wire logic                                        mclk,           // System clock
   input  wire logic                                        sys_rst,        // Sync reset, high
   input  wire sdpr_pkg::sdpr_ctrl_s [sdpr_pkg::NUM_PORTS-1:0] ctrl,        // Per-port controls
   input  wire logic [sdpr_pkg::NUM_PORTS-1:0]              output_disable, // Async float, high
   input  wire logic [sdpr_pkg::NUM_PORTS-1:0][ADDR_W-1:0]  addr,           // Address pins
   input  wire logic [sdpr_pkg::NUM_PORTS-1:0][DATA_W-1:0]  dq_i,           // Data pins in
   output logic      [sdpr_pkg::NUM_PORTS-1:0][DATA_W-1:0]  dq_o,           // Data pins out
   output logic      [sdpr_pkg::NUM_PORTS-1:0]              dq_oe           // Data drive enable
);

   localparam int NP = sdpr_pkg::NUM_PORTS;

   // ----------------------------------------------------------------------
   // Parameter checks
   // ----------------------------------------------------------------------
   if (ADDR_W < 1 || ADDR_W > 24) begin : g_bad_addr
      $error("sdpr_port_ram: ADDR_W out of range");
   end
   if (DATA_W < 1) begin : g_bad_data
      $error("sdpr_port_ram: DATA_W must be positive");
   end
   // A single clock period already exceeds the clock-to-clock spacing, so a
   // word written on one edge is read back new by the other port next edge.
   if (sdpr_pkg::CLK_TO_CLK_NS >= sdpr_pkg::CLK_PERIOD_NS) begin : g_bad_ccs
      $error("sdpr_port_ram: clock too fast for cross-port timing");
   end

   logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

   logic [NP-1:0][ADDR_W-1:0] cnt_ff;
   logic [NP-1:0][ADDR_W-1:0] nxt_acc;
   logic [NP-1:0]             sel;
   logic [NP-1:0]             wr_en;
   logic [NP-1:0][DATA_W-1:0] rd_word;
   logic [NP-1:0][DATA_W-1:0] stage_ff;
   logic [NP-1:0]             stage_drv_ff;
   logic [NP-1:0][DATA_W-1:0] dout_ff;
   logic [NP-1:0]             drive_ff;
   logic [NP-1:0]             rd_req;

   // ----------------------------------------------------------------------
   // Array writes
   // ----------------------------------------------------------------------
   // Port 1 is written last, so it wins a same-word collision; nothing is
   // promised there and the masters are expected to arbitrate.
   always_ff @(posedge mclk) begin
      for (int p = 0; p < NP; p++) begin
         if (wr_en[p]) begin
            mem[nxt_acc[p]] <= dq_i[p];
         end
      end
   end

   for (genvar p = 0; p < NP; p++) begin : g_port

      // --------------------------------------------------------------------
      // Select decode and access address
      // --------------------------------------------------------------------
      assign sel[p]   = !ctrl[p].select_active_low && ctrl[p].select_active_high;
      assign wr_en[p] = sel[p] && !ctrl[p].read_not_write;
      assign rd_req[p] = sel[p] && ctrl[p].read_not_write;

      always_comb begin
         if (!ctrl[p].count_clear_n) begin
            nxt_acc[p] = ADDR_W'(sdpr_pkg::CNT_CLEAR_VAL);
         end else if (!ctrl[p].address_load_strobe_n) begin
            nxt_acc[p] = addr[p];
         end else if (!ctrl[p].count_advance_n) begin
            // Natural overflow wraps the top address to zero.
            nxt_acc[p] = cnt_ff[p] + ADDR_W'(sdpr_pkg::CNT_STEP);
         end else begin
            nxt_acc[p] = cnt_ff[p];
         end
      end

      // Read is taken from the array before this edge's writes land, which is
      // the old word when the other port writes the same address this edge.
      assign rd_word[p] = mem[nxt_acc[p]];

      // --------------------------------------------------------------------
      // Burst counter, independent of the selects
      // --------------------------------------------------------------------
      always_ff @(posedge mclk) begin
         if (sys_rst) begin
            cnt_ff[p] <= '0;
         end else begin
            cnt_ff[p] <= nxt_acc[p];
         end
      end

      // --------------------------------------------------------------------
      // Output path
      // --------------------------------------------------------------------
      always_ff @(posedge mclk) begin
         if (sys_rst) begin
            stage_ff[p]     <= '0;
            stage_drv_ff[p] <= 1'b0;
         end else begin
            stage_ff[p]     <= rd_word[p];
            stage_drv_ff[p] <= sel[p] && ctrl[p].read_not_write;
         end
      end

      always_ff @(posedge mclk) begin
         if (sys_rst) begin
            dout_ff[p]  <= '0;
            drive_ff[p] <= 1'b0;
         end else if (ctrl[p].flow_or_pipe_select) begin
            dout_ff[p]  <= stage_ff[p];
            drive_ff[p] <= stage_drv_ff[p];
         end else begin
            dout_ff[p]  <= rd_word[p];
            drive_ff[p] <= sel[p] && ctrl[p].read_not_write;
         end
      end

      assign dq_o[p] = dout_ff[p];
      // The disable input is the one path that bypasses the clock, so the
      // enable is a gate after the flop rather than a flop of its own.
      assign dq_oe[p] = drive_ff[p] && !output_disable[p];

      // --------------------------------------------------------------------
      // Assertions
      // --------------------------------------------------------------------
      property p_clear;
         @(posedge mclk) disable iff (sys_rst)
            !ctrl[p].count_clear_n |=> cnt_ff[p] == '0;
      endproperty
      a_clear: assert property (p_clear) else $error("counter not cleared");

      property p_load;
         @(posedge mclk) disable iff (sys_rst)
            ctrl[p].count_clear_n && !ctrl[p].address_load_strobe_n
            |=> cnt_ff[p] == $past(addr[p]);
      endproperty
      a_load: assert property (p_load) else $error("address not loaded");

      property p_hold;
         @(posedge mclk) disable iff (sys_rst)
            ctrl[p].count_clear_n && ctrl[p].address_load_strobe_n
            && ctrl[p].count_advance_n |=> $stable(cnt_ff[p]);
      endproperty
      a_hold: assert property (p_hold) else $error("counter did not hold");

      property p_inc;
         @(posedge mclk) disable iff (sys_rst)
            ctrl[p].count_clear_n && ctrl[p].address_load_strobe_n
            && !ctrl[p].count_advance_n
            |=> cnt_ff[p] == ADDR_W'($past(cnt_ff[p]) + ADDR_W'(1));
      endproperty
      a_inc: assert property (p_inc) else $error("counter did not step");

      property p_ft_read;
         @(posedge mclk) disable iff (sys_rst)
            sel[p] && ctrl[p].read_not_write && !ctrl[p].flow_or_pipe_select
            |=> drive_ff[p] && dout_ff[p] == $past(rd_word[p]);
      endproperty
      a_ft_read: assert property (p_ft_read) else $error("flow read wrong");

      property p_pipe_read;
         @(posedge mclk) disable iff (sys_rst)
            sel[p] && ctrl[p].read_not_write ##1 ctrl[p].flow_or_pipe_select
            |=> drive_ff[p] && dout_ff[p] == $past(rd_word[p], 2);
      endproperty
      a_pipe_read: assert property (p_pipe_read) else $error("pipe read lag wrong");

      property p_ft_desel;
         @(posedge mclk) disable iff (sys_rst)
            !sel[p] && !ctrl[p].flow_or_pipe_select |=> !dq_oe[p];
      endproperty
      a_ft_desel: assert property (p_ft_desel) else $error("pins driven deselected");

      property p_pipe_desel;
         @(posedge mclk) disable iff (sys_rst)
            !sel[p] ##1 ctrl[p].flow_or_pipe_select |=> !dq_oe[p];
      endproperty
      a_pipe_desel: assert property (p_pipe_desel) else $error("pipe deselect late");

      // A pipelined read keeps driving for one cycle after deselection, so the
      // request that allows the drive lies one or two edges back by mode.
      property p_async_off;
         @(posedge mclk) disable iff (sys_rst)
            dq_oe[p] |-> !output_disable[p]
               && ($past(ctrl[p].flow_or_pipe_select) ? $past(rd_req[p], 2) : $past(rd_req[p]));
      endproperty
      a_async_off: assert property (p_async_off) else $error("drive while disabled");

      property p_oe_gate;
         @(posedge mclk) disable iff (sys_rst)
            output_disable[p] |-> !dq_oe[p];
      endproperty
      a_oe_gate: assert property (p_oe_gate) else $error("disable did not float pins");

      property p_ft_wr_quiet;
         @(posedge mclk) disable iff (sys_rst)
            wr_en[p] && !ctrl[p].flow_or_pipe_select |=> !drive_ff[p];
      endproperty
      a_ft_wr_quiet: assert property (p_ft_wr_quiet) else $error("flow write drove pins");

      property p_pipe_wr_quiet;
         @(posedge mclk) disable iff (sys_rst)
            wr_en[p] ##1 ctrl[p].flow_or_pipe_select |=> !drive_ff[p];
      endproperty
      a_pipe_wr_quiet: assert property (p_pipe_wr_quiet) else $error("pipe write drove pins");

      // A same-word write from the other port may win, so those edges are left out.
      localparam int OTHER = NP - 1 - p;
      property p_write_lands;
         @(posedge mclk) disable iff (sys_rst)
            wr_en[p] && !(wr_en[OTHER] && nxt_acc[OTHER] == nxt_acc[p])
            |=> mem[$past(nxt_acc[p])] == $past(dq_i[p]);
      endproperty
      a_write_lands: assert property (p_write_lands) else $error("write did not land");

      property p_clear_read;
         @(posedge mclk) disable iff (sys_rst)
            !ctrl[p].count_clear_n && rd_req[p] && !ctrl[p].flow_or_pipe_select
            |=> dq_o[p] == $past(mem[0]);
      endproperty
      a_clear_read: assert property (p_clear_read) else $error("clear read not word zero");

      property p_load_read;
         @(posedge mclk) disable iff (sys_rst)
            ctrl[p].count_clear_n && !ctrl[p].address_load_strobe_n && rd_req[p]
            && !ctrl[p].flow_or_pipe_select |=> dq_o[p] == $past(mem[addr[p]]);
      endproperty
      a_load_read: assert property (p_load_read) else $error("pin address not used");

      property p_hold_read;
         @(posedge mclk) disable iff (sys_rst)
            ctrl[p].count_clear_n && ctrl[p].address_load_strobe_n && ctrl[p].count_advance_n
            && rd_req[p] && !ctrl[p].flow_or_pipe_select
            |=> dq_o[p] == $past(mem[cnt_ff[p]]);
      endproperty
      a_hold_read: assert property (p_hold_read) else $error("hold read wrong word");

      property p_inc_read;
         @(posedge mclk) disable iff (sys_rst)
            ctrl[p].count_clear_n && ctrl[p].address_load_strobe_n && !ctrl[p].count_advance_n
            && rd_req[p] && !ctrl[p].flow_or_pipe_select
            |=> dq_o[p] == $past(mem[ADDR_W'(cnt_ff[p] + ADDR_W'(1))]);
      endproperty
      a_inc_read: assert property (p_inc_read) else $error("advance read wrong word");

      property p_wrap;
         @(posedge mclk) disable iff (sys_rst)
            ctrl[p].count_clear_n && ctrl[p].address_load_strobe_n && !ctrl[p].count_advance_n
            && cnt_ff[p] == '1 |=> cnt_ff[p] == '0;
      endproperty
      a_wrap: assert property (p_wrap) else $error("counter did not wrap");

      property p_pipe_late_off;
         @(posedge mclk) disable iff (sys_rst)
            rd_req[p] ##1 !sel[p] && ctrl[p].flow_or_pipe_select |=> drive_ff[p];
      endproperty
      a_pipe_late_off: assert property (p_pipe_late_off) else $error("pipe deselect early");

      // Memory words are not cleared by reset, so only counter and drive flags are checked.
      property p_reset_quiet;
         @(posedge mclk) sys_rst |=> !drive_ff[p] && !stage_drv_ff[p] && cnt_ff[p] == '0;
      endproperty
      a_reset_quiet: assert property (p_reset_quiet) else $error("reset left port active");

      // --------------------------------------------------------------------
      // Cover points
      // --------------------------------------------------------------------
      c_burst: cover property (@(posedge mclk) disable iff (sys_rst)
         !ctrl[p].address_load_strobe_n ##1 !ctrl[p].count_advance_n [*3]);
      c_pipe_rd: cover property (@(posedge mclk) disable iff (sys_rst)
         ctrl[p].flow_or_pipe_select && sel[p] && ctrl[p].read_not_write ##2 dq_oe[p]);
      c_clr_wr: cover property (@(posedge mclk) disable iff (sys_rst)
         !ctrl[p].count_clear_n && wr_en[p]);
      c_wrap: cover property (@(posedge mclk) disable iff (sys_rst)
         cnt_ff[p] == '1 ##1 cnt_ff[p] == '0);
      c_desel_load: cover property (@(posedge mclk) disable iff (sys_rst)
         !sel[p] && !ctrl[p].address_load_strobe_n);
   end

endmodule

// >>> hw/sdpr_pkg.sv
package sdpr_pkg;

   // ----------------------------------------------------------------------
   // Array shape and port count
   // ----------------------------------------------------------------------
   localparam int NUM_PORTS   = 2;
   localparam int DEF_ADDR_W  = 17;
   localparam int DEF_DATA_W  = 9;

   // ----------------------------------------------------------------------
   // Burst counter values
   // ----------------------------------------------------------------------
   localparam int CNT_CLEAR_VAL = 0;
   localparam int CNT_STEP      = 1;

   // ----------------------------------------------------------------------
   // Port-to-port timing
   // ----------------------------------------------------------------------
   localparam int CLK_PERIOD_NS     = 100;
   localparam int WR_TO_RD_DELAY_NS = 30;
   localparam int CLK_TO_CLK_NS     = 9;
   // A longest time rounds down, never below one cycle.
   localparam int WR_TO_RD_CYC = (WR_TO_RD_DELAY_NS / CLK_PERIOD_NS) < 1 ? 1 :
                                 (WR_TO_RD_DELAY_NS / CLK_PERIOD_NS);
   localparam int CLK_TO_CLK_CYC = (CLK_TO_CLK_NS / CLK_PERIOD_NS) < 1 ? 1 :
                                   (CLK_TO_CLK_NS / CLK_PERIOD_NS);

   // ----------------------------------------------------------------------
   // Control pins of one port, all sampled on the rising edge
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic select_active_low;
      logic select_active_high;
      logic read_not_write;
      logic address_load_strobe_n;
      logic count_advance_n;
      logic count_clear_n;
      logic flow_or_pipe_select;
   } sdpr_ctrl_s;

endpackage

// >>> tb/sdpr_master.sv
// ------------------------------------------------------------------
// Bus master on one port
// ------------------------------------------------------------------
module sdpr_master #(
   parameter int ADDR_W = 4,
   parameter int DATA_W = 9
) (
   input  wire logic              mclk,  // Shared clock
   input  wire logic [DATA_W-1:0] dq_o,  // Device read data
   input  wire logic              dq_oe, // Device drive enable
   output sdpr_pkg::sdpr_ctrl_s   ctrl,  // Port controls
   output logic [ADDR_W-1:0]      addr,  // Address pins
   output logic [DATA_W-1:0]      dq_i,  // Write data
   output wire logic [DATA_W-1:0] bus    // Resolved data pins
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [DATA_W-1:0] last;
   // An undriven pin shows the inverse of its last value so stale data never matches.
   assign bus = dq_oe ? dq_o : ~last;
   always @(posedge mclk) if (dq_oe) last <= dq_o;
   initial begin
      ctrl = 7'h5e;
      addr = '0;
      dq_i = '0;
      last = '0;
   end
   // Inputs change at the falling edge so they are stable at the sampling edge.
   task automatic op(input logic [1:0] sel, input logic rnw, ld_n, adv_n, clr_n, mode,
                     input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(negedge mclk);
      ctrl = '{sel[0], sel[1], rnw, ld_n, adv_n, clr_n, mode};
      addr = a;
      dq_i = rnw ? ~dq_i : d;
      @(posedge mclk);
      #1;
   endtask
endmodule

// >>> tb/sync_dual_port_ram_port_logic_bench.sv
module sync_dual_port_ram_port_logic_bench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int AW = 4;
   localparam int DW = sdpr_pkg::DEF_DATA_W;
   logic                       mclk;
   logic                       sys_rst;
   logic [1:0]                 output_disable;
   wire sdpr_pkg::sdpr_ctrl_s [1:0] ctrl;
   wire logic [1:0][AW-1:0]    addr;
   wire logic [1:0][DW-1:0]    dq_i;
   wire logic [1:0][DW-1:0]    bus;
   logic [1:0][DW-1:0]         dq_o;
   logic [1:0]                 dq_oe;
   int                         n_errors = 0;
   int                         n_compared = 0;
   int                         cyc = 0;

   sdpr_port_ram #(.ADDR_W(AW), .DATA_W(DW)) dut (.mclk(mclk), .sys_rst(sys_rst),
      .ctrl(ctrl), .output_disable(output_disable), .addr(addr), .dq_i(dq_i),
      .dq_o(dq_o), .dq_oe(dq_oe));
   sdpr_master #(.ADDR_W(AW), .DATA_W(DW)) m0 (.mclk(mclk), .dq_o(dq_o[0]),
      .dq_oe(dq_oe[0]), .ctrl(ctrl[0]), .addr(addr[0]), .dq_i(dq_i[0]), .bus(bus[0]));
   sdpr_master #(.ADDR_W(AW), .DATA_W(DW)) m1 (.mclk(mclk), .dq_o(dq_o[1]),
      .dq_oe(dq_oe[1]), .ctrl(ctrl[1]), .addr(addr[1]), .dq_i(dq_i[1]), .bus(bus[1]));

   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   task automatic test_done();
      if (n_errors == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [DW-1:0] e, input logic [DW-1:0] g);
      n_compared++;
      if (g !== e) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Hang guard: the whole sequence needs well under this many cycles.
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 400) begin
         n_errors++;
         test_done();
      end
   end

   task automatic t_flow();
      m0.op(2'b10, 0, 0, 1, 1, 0, 4'h3, 9'h15a);
      chk("write drive", 9'h000, {8'h00, dq_oe[0]});
      m1.op(2'b10, 1, 0, 1, 1, 0, 4'h3, 9'h000);
      chk("cross read", 9'h15a, bus[1]);
      m0.op(2'b10, 1, 0, 1, 1, 0, 4'h3, 9'h000);
      chk("flow read", 9'h15a, bus[0]);
   endtask

   task automatic t_pipe();
      m0.op(2'b10, 0, 0, 1, 1, 1, 4'h7, 9'h0a5);
      m0.op(2'b10, 1, 0, 1, 1, 1, 4'h7, 9'h000);
      chk("pipe early", 9'h000, {8'h00, dq_oe[0]});
      m0.op(2'b11, 1, 1, 1, 1, 1, 4'h7, 9'h000);
      chk("pipe data", 9'h0a5, bus[0]);
      m0.op(2'b11, 1, 1, 1, 1, 1, 4'h7, 9'h000);
      chk("pipe desel", 9'h000, {8'h00, dq_oe[0]});
   endtask

   task automatic t_count();
      m0.op(2'b10, 0, 0, 1, 1, 0, 4'hf, 9'h0ff);
      m0.op(2'b10, 0, 0, 1, 1, 0, 4'h0, 9'h111);
      m0.op(2'b10, 0, 0, 1, 1, 0, 4'h1, 9'h022);
      m0.op(2'b00, 1, 0, 1, 1, 0, 4'he, 9'h000);
      m0.op(2'b10, 1, 1, 0, 1, 0, 4'h1, 9'h000);
      chk("advance", 9'h0ff, bus[0]);
      m0.op(2'b10, 1, 1, 0, 1, 0, 4'h1, 9'h000);
      chk("wrap", 9'h111, bus[0]);
      m0.op(2'b10, 1, 1, 1, 1, 0, 4'hf, 9'h000);
      chk("hold", 9'h111, bus[0]);
      m0.op(2'b10, 1, 1, 0, 1, 0, 4'hf, 9'h000);
      chk("advance one", 9'h022, bus[0]);
      m0.op(2'b10, 1, 0, 0, 0, 0, 4'hf, 9'h000);
      chk("clear", 9'h111, bus[0]);
      m0.op(2'b10, 1, 0, 0, 1, 0, 4'h1, 9'h000);
      chk("load", 9'h022, bus[0]);
   endtask

   task automatic t_gate();
      @(negedge mclk);
      output_disable[0] = 1'b1;
      #1;
      chk("disable", 9'h000, {8'h00, dq_oe[0]});
      @(negedge mclk);
      output_disable[0] = 1'b0;
      #1;
      chk("enable", 9'h022, bus[0]);
      m0.op(2'b11, 0, 0, 1, 1, 0, 4'h1, 9'h1ff);
      chk("desel low", 9'h000, {8'h00, dq_oe[0]});
      m0.op(2'b00, 0, 0, 1, 1, 0, 4'h1, 9'h1ff);
      chk("desel high", 9'h000, {8'h00, dq_oe[0]});
      m0.op(2'b10, 1, 0, 1, 1, 0, 4'h1, 9'h000);
      chk("no write", 9'h022, bus[0]);
      m0.op(2'b10, 0, 0, 1, 1, 0, 4'h1, 9'h0c3);
      m0.op(2'b10, 1, 0, 1, 1, 0, 4'h1, 9'h000);
      chk("rewrite", 9'h0c3, bus[0]);
   endtask

   initial begin
      sys_rst = 1'b1;
      output_disable = 2'b00;
      repeat (8) @(negedge mclk);
      sys_rst = 1'b0;
      t_flow();
      t_pipe();
      t_count();
      t_gate();
      test_done();
   end
endmodule
